// file: verilog/jat_cfg.svh
/*
 * constants for the J1939 ambient / aftertreatment framer: identifier
 * fields, group numbers, scaling offsets, not-available codes, timing.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef JAT_CFG_SVH
`define JAT_CFG_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define JAT_CLK_HZ            40000000
`define JAT_HALF_SEC_MS       500
`define JAT_HALF_SEC_CYC      (`JAT_HALF_SEC_MS * (`JAT_CLK_HZ / 1000))
`define JAT_TMR_W             26

// ----------------------------------------------------------------------
// identifier fields of all four groups; priority, EDP and DP common to all
// ----------------------------------------------------------------------
`define JAT_PRIO              3'h6
`define JAT_EDP               1'h0
`define JAT_DP                1'h0
`define JAT_PF_AMB            8'hFE
`define JAT_PS_AMB            8'hF5
`define JAT_PF_ATI2           8'hFD
`define JAT_PS_ATI2           8'hB4
`define JAT_PF_ATO2           8'hFD
`define JAT_PS_ATO2           8'hB3
`define JAT_PF_CCSS           8'hFE
`define JAT_PS_CCSS           8'hED
`define JAT_PGN_AMB           18'h0FEF5
`define JAT_PGN_ATI2          18'h0FDB4
`define JAT_PGN_ATO2          18'h0FDB3
`define JAT_PGN_CCSS          18'h0FEED
`define JAT_ADDR_GLOBAL       8'hFF

// ----------------------------------------------------------------------
// field positions inside the 29-bit identifier
// ----------------------------------------------------------------------
`define JAT_ID_PRIO_LSB       26
`define JAT_ID_EDP_BIT        25
`define JAT_ID_DP_BIT         24
`define JAT_ID_PF_LSB         16
`define JAT_ID_PS_LSB         8

// ----------------------------------------------------------------------
// scaling: 16-bit temps are 1/32 degC, offset 273 degC = 0x2220 counts
// ----------------------------------------------------------------------
`define JAT_TEMP16_OFS        18'sh02220
`define JAT_TEMP8_OFS         10'sh028
`define JAT_RAW8_MAX          8'hFA
`define JAT_NA8               8'hFF
`define JAT_NA16              16'hFFFF

`define JAT_FIFO_DEPTH        8

`endif

// file: verilog/jat_pkg.sv
/*
 * types of the J1939 framer: frame carrier, group select, scheduler states.
 * assumes jat_cfg.svh is on the include path.
 */
package jat_pkg;
    `include "jat_cfg.svh"

    // byte 1 of the payload is data[7:0], transmitted first
    typedef struct packed {
        logic [28:0] id;
        logic [63:0] data;
    } jat_frame_s;

    typedef enum logic [1:0] {
        JAT_GRP_AMB  = 2'h0,
        JAT_GRP_ATI2 = 2'h1,
        JAT_GRP_ATO2 = 2'h2,
        JAT_GRP_CCSS = 2'h3
    } jat_grp_e;

    typedef enum logic [1:0] {
        JAT_ST_IDLE = 2'h0,
        JAT_ST_LOAD = 2'h1,
        JAT_ST_PUSH = 2'h3
    } jat_state_e;
endpackage : jat_pkg

// file: verilog/jat_fifo.sv
/*
 * synchronous FIFO with valid/ready on both sides.
 * assumes one clock, a clock enable and an active-low async reset.
 */
`timescale 1ns/1ps
module jat_fifo #(
    parameter int WIDTH = 93,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // storage has no reset; out_data is only taken while count is non-zero
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                                                           : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                                                           : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : jat_fifo

// file: verilog/jat_framer.sv
/*
 * J1939 framer for ambient conditions, aftertreatment intake gas 2,
 * aftertreatment outlet gas 2 and cruise control / vehicle speed setup.
 * assumes all inputs come from logic on clk_sys (CAN controller receive
 * path and sensor processing); the frame output feeds a CAN transmitter.
 */

`timescale 1ns/1ps
module jat_framer
    import jat_pkg::*;
#(
    parameter int HALF_SEC_CYC = `JAT_HALF_SEC_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               ce,
    input  wire logic [7:0]         own_addr,
    input  wire logic [7:0]         baro_cnt,
    input  wire logic               baro_ok,
    input  wire logic signed [15:0] amb_temp_q5,
    input  wire logic               amb_temp_ok,
    input  wire logic signed [8:0]  inlet_temp_c,
    input  wire logic               inlet_temp_ok,
    input  wire logic signed [15:0] trap_in_q5,
    input  wire logic               trap_in_ok,
    input  wire logic signed [15:0] trap_out_q5,
    input  wire logic               trap_out_ok,
    input  wire logic [7:0]         max_spd_kmh,
    input  wire logic               max_spd_ok,
    input  wire logic [7:0]         cc_hi_kmh,
    input  wire logic               cc_hi_ok,
    input  wire logic [7:0]         cc_lo_kmh,
    input  wire logic               cc_lo_ok,
    input  wire logic               req_valid,
    input  wire logic [17:0]        req_pgn,
    input  wire logic [7:0]         req_dst,
    output jat_frame_s              tx_frame,
    output logic                    tx_valid,
    input  wire logic               tx_ready,
    output logic                    req_taken,
    output logic                    tick_lost
);

    // ------------------------------------------------------------------
    // scaling helpers
    // ------------------------------------------------------------------
    // 1/32 degC signed input; below -273 degC clamps to zero counts
    function automatic logic [15:0] jat_temp16(
        input logic signed [15:0] t,
        input logic               ok
    );
        logic signed [17:0] s;
        s = {{2{t[15]}}, t} + `JAT_TEMP16_OFS;
        if (!ok) begin
            jat_temp16 = `JAT_NA16;
        end else if (s < 0) begin
            jat_temp16 = 16'h0000;
        end else begin
            jat_temp16 = s[15:0];
        end
    endfunction : jat_temp16

    // whole degC signed input, 1 degC/count, -40 degC offset
    function automatic logic [7:0] jat_temp8(
        input logic signed [8:0] t,
        input logic              ok
    );
        logic signed [9:0] s;
        s = {t[8], t} + `JAT_TEMP8_OFS;
        if (!ok) begin
            jat_temp8 = `JAT_NA8;
        end else if (s < 0) begin
            jat_temp8 = 8'h00;
        end else if (s > $signed({2'h0, `JAT_RAW8_MAX})) begin
            jat_temp8 = `JAT_RAW8_MAX;
        end else begin
            jat_temp8 = s[7:0];
        end
    endfunction : jat_temp8

    // codes above 0xFA are reserved for error / not-available markers
    function automatic logic [7:0] jat_raw8(
        input logic [7:0] v,
        input logic       ok
    );
        if (!ok) begin
            jat_raw8 = `JAT_NA8;
        end else if (v > `JAT_RAW8_MAX) begin
            jat_raw8 = `JAT_RAW8_MAX;
        end else begin
            jat_raw8 = v;
        end
    endfunction : jat_raw8

    function automatic logic [28:0] jat_make_id(
        input logic [7:0] pf,
        input logic [7:0] ps,
        input logic [7:0] sa
    );
        logic [28:0] id;
        id = '0;
        id[`JAT_ID_PRIO_LSB +: 3] = `JAT_PRIO;
        id[`JAT_ID_EDP_BIT]       = `JAT_EDP;
        id[`JAT_ID_DP_BIT]        = `JAT_DP;
        id[`JAT_ID_PF_LSB +: 8]   = pf;
        id[`JAT_ID_PS_LSB +: 8]   = ps;
        id[7:0]                   = sa;
        jat_make_id = id;
    endfunction : jat_make_id

    // ------------------------------------------------------------------
    // repetition timer
    // ------------------------------------------------------------------
    // one 500 ms base; ambient fires on every second tick
    logic [`JAT_TMR_W-1:0] tmr_reg;
    logic                  amb_phase_reg;
    logic                  half_tick;

    assign half_tick = (tmr_reg == `JAT_TMR_W'(HALF_SEC_CYC - 1));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tmr_reg       <= '0;
            amb_phase_reg <= 1'b0;
        end else if (ce) begin
            if (half_tick) begin
                tmr_reg       <= '0;
                amb_phase_reg <= !amb_phase_reg;
            end else begin
                tmr_reg <= tmr_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    logic req_for_us;
    logic [3:0] req_set;

    // PDU2 groups are broadcast, so the reply goes to everyone
    assign req_for_us = req_valid && ((req_dst == own_addr) ||
                                      (req_dst == `JAT_ADDR_GLOBAL));

    always_comb begin
        req_set = 4'h0;
        if (req_for_us) begin
            unique case (req_pgn)
                `JAT_PGN_AMB:  req_set[JAT_GRP_AMB]  = 1'b1;
                `JAT_PGN_ATI2: req_set[JAT_GRP_ATI2] = 1'b1;
                `JAT_PGN_ATO2: req_set[JAT_GRP_ATO2] = 1'b1;
                `JAT_PGN_CCSS: req_set[JAT_GRP_CCSS] = 1'b1;
                default:       req_set = 4'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_taken <= 1'b0;
        end else if (ce) begin
            req_taken <= (req_set != 4'h0);
        end
    end

    // ------------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------------
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic [3:0] tmr_set;
    logic [3:0] pend_clr;
    logic [3:0] pend_set;

    always_comb begin
        tmr_set = 4'h0;
        tmr_set[JAT_GRP_AMB]  = half_tick && amb_phase_reg;
        tmr_set[JAT_GRP_ATI2] = half_tick;
        tmr_set[JAT_GRP_ATO2] = half_tick;
        tmr_set[JAT_GRP_CCSS] = 1'b0;
    end

    assign pend_set  = tmr_set | req_set;
    // a new cause in the clearing cycle keeps the flag set
    assign pend_next = (pend_reg & ~pend_clr) | pend_set;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= 4'h0;
        end else if (ce) begin
            pend_reg <= pend_next;
        end
    end

    // a periodic tick finding its group still waiting is merged, flagged
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_lost <= 1'b0;
        end else if (ce) begin
            tick_lost <= |(tmr_set & pend_reg & ~pend_clr);
        end
    end

    // ------------------------------------------------------------------
    // scheduler
    // ------------------------------------------------------------------
    jat_state_e state_reg;
    jat_grp_e   grp_reg;
    jat_grp_e   grp_pick;
    jat_frame_s build_reg;
    jat_frame_s build_next;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    jat_frame_s fifo_out_data;

    always_comb begin
        grp_pick = JAT_GRP_CCSS;
        if (pend_reg[JAT_GRP_AMB]) begin
            grp_pick = JAT_GRP_AMB;
        end else if (pend_reg[JAT_GRP_ATI2]) begin
            grp_pick = JAT_GRP_ATI2;
        end else if (pend_reg[JAT_GRP_ATO2]) begin
            grp_pick = JAT_GRP_ATO2;
        end
    end

    always_comb begin
        pend_clr = 4'h0;
        if (state_reg == JAT_ST_IDLE && pend_reg != 4'h0) begin
            pend_clr[grp_pick] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= JAT_ST_IDLE;
            grp_reg   <= JAT_GRP_AMB;
        end else if (ce) begin
            unique case (state_reg)
                JAT_ST_IDLE: begin
                    if (pend_reg != 4'h0) begin
                        grp_reg   <= grp_pick;
                        state_reg <= JAT_ST_LOAD;
                    end
                end
                JAT_ST_LOAD: begin
                    state_reg <= JAT_ST_PUSH;
                end
                JAT_ST_PUSH: begin
                    // full FIFO stalls here; pending flags keep collecting
                    if (fifo_in_ready) begin
                        state_reg <= JAT_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= JAT_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // payload assembly
    // ------------------------------------------------------------------
    // inputs are sampled at load, so a frame is one coherent snapshot
    always_comb begin
        logic [7:0]  b [8];
        logic [15:0] t16;
        logic [7:0]  pf;
        logic [7:0]  ps;
        for (int i = 0; i < 8; i++) begin
            b[i] = `JAT_NA8;
        end
        t16 = `JAT_NA16;
        pf  = `JAT_PF_AMB;
        ps  = `JAT_PS_AMB;
        unique case (grp_reg)
            JAT_GRP_AMB: begin
                b[0] = jat_raw8(baro_cnt, baro_ok);
                t16  = jat_temp16(amb_temp_q5, amb_temp_ok);
                b[3] = t16[7:0];
                b[4] = t16[15:8];
                b[5] = jat_temp8(inlet_temp_c, inlet_temp_ok);
            end
            JAT_GRP_ATI2: begin
                // bytes 1-2, 5-8 stay not-available
                t16  = jat_temp16(trap_in_q5, trap_in_ok);
                b[2] = t16[7:0];
                b[3] = t16[15:8];
                pf   = `JAT_PF_ATI2;
                ps   = `JAT_PS_ATI2;
            end
            JAT_GRP_ATO2: begin
                // bytes 1-2, 5-8 stay not-available
                t16  = jat_temp16(trap_out_q5, trap_out_ok);
                b[2] = t16[7:0];
                b[3] = t16[15:8];
                pf   = `JAT_PF_ATO2;
                ps   = `JAT_PS_ATO2;
            end
            JAT_GRP_CCSS: begin
                b[0] = jat_raw8(max_spd_kmh, max_spd_ok);
                b[1] = jat_raw8(cc_hi_kmh, cc_hi_ok);
                b[2] = jat_raw8(cc_lo_kmh, cc_lo_ok);
                pf   = `JAT_PF_CCSS;
                ps   = `JAT_PS_CCSS;
            end
        endcase
        build_next.id   = jat_make_id(pf, ps, own_addr);
        build_next.data = {b[7], b[6], b[5], b[4], b[3], b[2], b[1], b[0]};
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            build_reg <= '0;
        end else if (ce && state_reg == JAT_ST_LOAD) begin
            build_reg <= build_next;
        end
    end

    // ------------------------------------------------------------------
    // frame queue and output stage
    // ------------------------------------------------------------------
    jat_fifo #(
        .WIDTH ($bits(jat_frame_s)),
        .DEPTH (`JAT_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .ce        (ce),
        .in_valid  (state_reg == JAT_ST_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (build_reg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = !tx_valid || tx_ready;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
        end else if (ce && fifo_out_ready) begin
            tx_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                tx_frame <= fifo_out_data;
            end
        end
    end

endmodule : jat_framer

// file: tb/jat_sink.sv
/*
 * far-side model: CAN transmitter taking frames by valid/ready.
 * assumes one clock; stall is set by the bench to hold ready low.
 */
`timescale 1ns/1ps
module jat_sink
    import jat_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire jat_frame_s tx_frame,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic       stall = 1'b0;
    jat_frame_s q[$];
    int         qt[$];
    int         cyc = 0;

    initial tx_ready = 1'b0;

    // stamp each taken frame with its cycle for rate checks
    always @(posedge clk_sys) begin
        cyc++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            q.push_back(tx_frame);
            qt.push_back(cyc);
        end
        tx_ready <= #2 !stall;
    end
endmodule : jat_sink

// file: tb/jat_framer_chk.sv
/*
 * checker for jat_framer: identifier, unused bytes, request handshake.
 * assumes it is bound to every jat_framer instance.
 */
`timescale 1ns/1ps
module jat_framer_chk
    import jat_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        ce,
    input wire logic [7:0]  own_addr,
    input wire logic        req_valid,
    input wire logic [17:0] req_pgn,
    input wire logic [7:0]  req_dst,
    input wire jat_frame_s  tx_frame,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        req_taken
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    logic [15:0] pfps;
    logic        hit;
    logic [3:0]  ccss_reg;
    assign pfps = tx_frame.id[23:8];
    assign hit  = req_valid && ce && (req_dst == own_addr
                  || req_dst == 8'hFF) && req_pgn inside
                  {18'h0FEF5, 18'h0FDB4, 18'h0FDB3, 18'h0FEED};

    // outstanding speed setup requests; merged ones leave it above zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) ccss_reg <= 4'h0;
        else ccss_reg <= ccss_reg + 4'(hit && req_pgn == 18'h0FEED)
            - 4'(tx_valid && tx_ready && pfps == 16'hFEED && ccss_reg != 0);
    end

    a_req_ack: assert property (hit |=> req_taken)
        else $error("request not acknowledged");
    a_req_quiet: assert property (!hit |=> !req_taken)
        else $error("request acknowledged wrongly");
    a_tx_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_frame))
        else $error("frame changed before taken");
    a_id_head: assert property (tx_valid |->
        tx_frame.id[28:24] == 5'h18 && tx_frame.id[7:0] == own_addr)
        else $error("identifier head wrong");
    a_grp_known: assert property (tx_valid |->
        pfps inside {16'hFEF5, 16'hFDB4, 16'hFDB3, 16'hFEED})
        else $error("unknown group");
    a_amb_na: assert property (tx_valid && pfps == 16'hFEF5 |->
        tx_frame.data[23:8] == 16'hFFFF
        && tx_frame.data[63:48] == 16'hFFFF)
        else $error("ambient unused byte");
    a_gas_na: assert property (tx_valid &&
        pfps[15:8] == 8'hFD |-> tx_frame.data[15:0] == 16'hFFFF
        && tx_frame.data[63:32] == 32'hFFFFFFFF)
        else $error("gas unused byte");
    a_ccss_na: assert property (tx_valid && pfps == 16'hFEED |->
        tx_frame.data[63:24] == 40'hFFFFFFFFFF)
        else $error("setup undefined byte");
    a_ccss_asked: assert property (tx_valid && pfps == 16'hFEED |->
        ccss_reg != 4'h0)
        else $error("setup sent unasked");

    c_ccss: cover property (tx_valid && tx_ready && pfps == 16'hFEED);
    c_amb: cover property (tx_valid && tx_ready && pfps == 16'hFEF5);
    c_stall: cover property (tx_valid && !tx_ready [*8]);
endmodule : jat_framer_chk

bind jat_framer jat_framer_chk u_chk (.clk_sys(clk_sys),
    .arst_n(arst_n), .ce(ce), .own_addr(own_addr),
    .req_valid(req_valid), .req_pgn(req_pgn), .req_dst(req_dst),
    .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .req_taken(req_taken));

// file: tb/tb.sv
/*
 * testbench for jat_framer: rates, payloads, requests, back-pressure.
 * assumes jat_sink as far side and a shortened half-second count.
 */
`timescale 1ns/1ps
module tb;
    import jat_pkg::*;
    localparam int         HS = 20;
    localparam logic [7:0] SA = 8'h3A;

    logic               clk_sys, arst_n, ce, req_valid, tx_ready;
    logic               tx_valid, req_taken, tick_lost;
    logic               baro_ok, amb_temp_ok, inlet_temp_ok, trap_in_ok;
    logic               trap_out_ok, max_spd_ok, cc_hi_ok, cc_lo_ok;
    logic [7:0]         own_addr, baro_cnt, max_spd_kmh, cc_hi_kmh;
    logic [7:0]         cc_lo_kmh, req_dst;
    logic [17:0]        req_pgn;
    logic signed [15:0] amb_temp_q5, trap_in_q5, trap_out_q5;
    logic signed [8:0]  inlet_temp_c;
    jat_frame_s         tx_frame;
    int                 bad_count = 0, n_checks = 0, n_taken, n_lost;

    jat_framer #(.HALF_SEC_CYC(HS)) dut (.clk_sys, .arst_n, .ce,
        .own_addr, .baro_cnt, .baro_ok, .amb_temp_q5, .amb_temp_ok,
        .inlet_temp_c, .inlet_temp_ok, .trap_in_q5, .trap_in_ok,
        .trap_out_q5, .trap_out_ok, .max_spd_kmh, .max_spd_ok,
        .cc_hi_kmh, .cc_hi_ok, .cc_lo_kmh, .cc_lo_ok, .req_valid,
        .req_pgn, .req_dst, .tx_frame, .tx_valid, .tx_ready,
        .req_taken, .tick_lost);
    jat_sink sink (.clk_sys, .tx_frame, .tx_valid, .tx_ready);

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (req_taken === 1'b1) n_taken++;
        if (tick_lost === 1'b1) n_lost++;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk_f(string nm, jat_frame_s e, jat_frame_s g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk_f

    task automatic chk_i(string nm, int e, int g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_i

    function automatic jat_frame_s fr(logic [15:0] g, logic [63:0] d);
        return {3'h6, 2'h0, g, SA, d};
    endfunction : fr

    // skip frames of other groups; bounded so a silent design ends the run
    task automatic get_f(logic [7:0] ps, output jat_frame_s f,
                         output int t);
        for (int i = 0; i < 400; i++) begin
            while (sink.q.size() > 0) begin
                f = sink.q.pop_front();
                t = sink.qt.pop_front();
                if (f.id[15:8] === ps) return;
            end
            @(posedge clk_sys);
        end
        bad_count++;
        $display("mismatch frame exp %h got none", ps);
        stop_test();
    endtask : get_f

    // n above one gives back-to-back requests
    task automatic send_req(logic [17:0] pgn, logic [7:0] dst, int n);
        @(posedge clk_sys);
        #2;
        {req_valid, req_pgn, req_dst} = {1'b1, pgn, dst};
        repeat (n) @(posedge clk_sys);
        #2;
        req_valid = 1'b0;
    endtask : send_req

    task automatic s_periodic;
        jat_frame_s  f;
        int          t0, t1;
        logic [15:0] g[3] = '{16'hFEF5, 16'hFDB4, 16'hFDB3};
        int          per[3] = '{4 * HS, 2 * HS, 2 * HS};
        logic [63:0] d[3] = '{64'hFFFF_4125_40FF_FFC8,
            64'hFFFF_FFFF_1F20_FFFF, 64'hFFFF_FFFF_3220_FFFF};
        for (int i = 0; i < 3; i++) begin
            get_f(g[i][7:0], f, t0);
            // two periods apart: the first and third frame of the group are compared
            get_f(g[i][7:0], f, t1);
            get_f(g[i][7:0], f, t1);
            chk_i("period", per[i], t1 - t0);
            chk_f("payload", fr(g[i], d[i]), f);
        end
    endtask : s_periodic

    task automatic s_request;
        jat_frame_s f;
        int         t;
        n_taken = 0;
        send_req(18'h0FEED, SA ^ 8'h01, 1);
        send_req(18'h0FEF1, SA, 1);
        repeat (8) @(posedge clk_sys);
        chk_i("refused", 0, n_taken);
        send_req(18'h0FEED, 8'hFF, 2);
        repeat (4) @(posedge clk_sys);
        chk_i("taken", 2, n_taken);
        get_f(8'hED, f, t);
        chk_f("setup", fr(16'hFEED, 64'hFFFF_FFFF_FF28_7864), f);
    endtask : s_request

    // every source invalid: each group must go out all ones
    task automatic s_na;
        jat_frame_s f;
        int         t;
        logic [15:0] g[4] = '{16'hFEED, 16'hFEF5, 16'hFDB4, 16'hFDB3};
        @(posedge clk_sys);
        #2;
        {baro_ok, amb_temp_ok, inlet_temp_ok, trap_in_ok} = 4'h0;
        {trap_out_ok, max_spd_ok, cc_hi_ok, cc_lo_ok} = 4'h0;
        repeat (12) @(posedge clk_sys);
        sink.q.delete();
        sink.qt.delete();
        send_req(18'h0FEED, SA, 1);
        for (int i = 0; i < 4; i++) begin
            get_f(g[i][7:0], f, t);
            chk_f("na", fr(g[i], '1), f);
        end
        #2;
        {baro_ok, amb_temp_ok, inlet_temp_ok, trap_in_ok} = 4'hF;
        {trap_out_ok, max_spd_ok, cc_hi_ok, cc_lo_ok} = 4'hF;
    endtask : s_na

    // fill the FIFO until it refuses, then drain it
    task automatic s_stall;
        n_lost = 0;
        #2;
        sink.stall = 1'b1;
        repeat (300) @(posedge clk_sys);
        chk_i("merged", 1, int'(n_lost > 0));
        #2;
        sink.q.delete();
        sink.qt.delete();
        sink.stall = 1'b0;
        repeat (30) @(posedge clk_sys);
        chk_i("drained", 1, int'(sink.q.size() >= 8));
    endtask : s_stall

    initial begin
        {arst_n, ce, own_addr, req_valid, req_pgn, req_dst} = {2'b01, SA,
            27'h0};
        {baro_cnt, amb_temp_q5, inlet_temp_c} = {8'hC8, 16'h0320, 9'h019};
        {trap_in_q5, trap_out_q5} = {16'hFD00, 16'h1000};
        {max_spd_kmh, cc_hi_kmh, cc_lo_kmh} = {8'h64, 8'h78, 8'h28};
        {baro_ok, amb_temp_ok, inlet_temp_ok, trap_in_ok} = 4'hF;
        {trap_out_ok, max_spd_ok, cc_hi_ok, cc_lo_ok} = 4'hF;
        repeat (12) @(posedge clk_sys);
        #2;
        arst_n = 1'b1;
        s_periodic();
        s_request();
        s_na();
        s_stall();
        stop_test();
    end
endmodule : tb
